/* File: common/dithered_clock_map.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef DITHERED_CLOCK_MAP_VH
`define DITHERED_CLOCK_MAP_VH
// Register and command locations
`define ADDR_DIV_HI     8'h02
`define ADDR_DIV_LO     8'h03
`define ADDR_TRIM_HI    8'h08
`define ADDR_TRIM_LO    8'h09
`define ADDR_BUS_NV     8'h0d
`define ADDR_BAND       8'h0e
`define ADDR_FACTORY    8'h37
`define ADDR_COMMIT     8'h3f
// Divider and dither word fields, and the inhibit bit of the bus register
`define DIV_RATE_HI     15
`define DIV_RATE_LO     14
`define DIV_DEPTH_HI    13
`define DIV_DEPTH_LO    11
`define DIV_IDLE_LOW    10
`define DIV_EXP_HI      9
`define DIV_EXP_LO      6
`define BUSNV_INHIBIT   3
// Reset values and exponent limit
`define RST_DIV         16'h6000
`define RST_TRIM        10'h1f4
`define RST_BUSNV       4'h0
`define EXP_MAX         4'h8
// Dither rate divisors
`define RATE_DIV_8192   14'h2000
`define RATE_DIV_4096   14'h1000
`define RATE_DIV_2048   14'h0800
// Dither spread in tenths of a percent, and trim step in kHz
`define DEPTH_0P5       7'h05
`define DEPTH_1         7'h0a
`define DEPTH_2         7'h14
`define DEPTH_4         7'h28
`define DEPTH_8         7'h50
`define TRIM_STEP_KHZ   13'h0005
// Timing: storage write cycle in block clocks, 10 ms at 20 MHz
`define NV_WRITE_COUNT  18'h3_0d40
// Arbitrary device identifier, upper part of the slave address
`define DEV_ID          4'h5
`endif

/* File: hdl/dithered_clock_config_regs.v */
// Configuration registers and two-wire slave of a dithered clock generator
`timescale 1ns/1ps
`include "dithered_clock_map.vh"

module dithered_clock_config_regs #(
  parameter [17:0] NV_WRITE_CYCLES = `NV_WRITE_COUNT,
  parameter [4:0]  FACTORY_BAND    = 5'h10
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  input  wire        dither_enable_pin,
  input  wire        output_enable_pin,
  input  wire        powerdown_n_pin,
  input  wire        power_cycle,
  output reg         osc_run,
  output reg         out_buffer_en,
  output reg         out_idle_low,
  output reg         out_idle_hiz,
  output reg  [3:0]  divide_exponent,
  output reg  [13:0] dither_rate_div,
  output reg  [6:0]  dither_spread,
  output reg  [9:0]  osc_trim,
  output reg  [12:0] trim_offset_khz,
  output reg  [4:0]  band_sel,
  output wire        nv_busy
);

  localparam [4:0] S_IDLE  = 5'b00001;
  localparam [4:0] S_RX    = 5'b00010;
  localparam [4:0] S_RXACK = 5'b00100;
  localparam [4:0] S_TX    = 5'b01000;
  localparam [4:0] S_TXACK = 5'b10000;

  // Synchronisers for pins
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg       scl_d;
  reg       sda_d;
  reg [1:0] dith_sync;
  reg [1:0] oe_sync;
  reg [1:0] pdn_sync;
  reg [1:0] pwr_sync;
  reg       pwr_d;

  // Volatile copies and nonvolatile storage
  reg [15:0] div_word;
  reg [9:0]  trim;
  reg [3:0]  bus_nv;
  reg [4:0]  band;
  reg [15:0] nv_div;
  reg [9:0]  nv_trim;
  reg [3:0]  nv_bus;
  reg [4:0]  nv_band;
  reg [17:0] nv_cnt;
  reg        commit_all;
  reg        commit_addr;

  // Serial slave state
  reg [4:0] state;
  reg [3:0] bit_cnt;
  reg [1:0] byte_idx;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  reg [7:0] ptr;
  reg [7:0] stage;
  reg       rw;
  reg [7:0] rd_byte;

  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  wire start    = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire stop     = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  wire recall   = pwr_sync[1] & ~pwr_d;
  wire inhibit  = bus_nv[`BUSNV_INHIBIT];

  assign sda_out = 1'b0;
  assign nv_busy = (nv_cnt != 18'h0_0000);

  // Clamp of the divider exponent
  function [3:0] clamp_exp;
    input [3:0] e;
    begin
      clamp_exp = (e > `EXP_MAX) ? `EXP_MAX : e;
    end
  endfunction

  // Two-stage synchronisers and edge history
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_sync  <= 2'b11;
      sda_sync  <= 2'b11;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      dith_sync <= 2'b00;
      oe_sync   <= 2'b00;
      pdn_sync  <= 2'b00;
      pwr_sync  <= 2'b00;
      pwr_d     <= 1'b0;
    end
    else
    begin
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      scl_d     <= scl_sync[1];
      sda_d     <= sda_sync[1];
      dith_sync <= {dith_sync[0], dither_enable_pin};
      oe_sync   <= {oe_sync[0], output_enable_pin};
      pdn_sync  <= {pdn_sync[0], powerdown_n_pin};
      pwr_sync  <= {pwr_sync[0], power_cycle};
      pwr_d     <= pwr_sync[1];
    end
  end

  // Read data selection
  always @*
  begin
    rd_byte = 8'h00;
    if (ptr == `ADDR_DIV_HI)
      rd_byte = div_word[15:8];
    else if (ptr == `ADDR_DIV_LO)
      rd_byte = {div_word[7:6], 6'h00};
    else if (ptr == `ADDR_TRIM_HI)
      rd_byte = trim[9:2];
    else if (ptr == `ADDR_TRIM_LO)
      rd_byte = {trim[1:0], 6'h00};
    else if (ptr == `ADDR_BUS_NV)
      rd_byte = {4'hf, bus_nv};
    else if (ptr == `ADDR_BAND)
      rd_byte = {3'b111, band};
    else if (ptr == `ADDR_FACTORY)
      rd_byte = {3'b000, FACTORY_BAND};
  end

  // Serial slave and volatile registers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state       <= S_IDLE;
      bit_cnt     <= 4'h0;
      byte_idx    <= 2'b00;
      rx_sh       <= 8'h00;
      tx_sh       <= 8'h00;
      ptr         <= 8'h00;
      stage       <= 8'h00;
      rw          <= 1'b0;
      sda_oe      <= 1'b0;
      commit_all  <= 1'b0;
      commit_addr <= 1'b0;
      div_word    <= `RST_DIV;
      trim        <= `RST_TRIM;
      bus_nv      <= `RST_BUSNV;
      band        <= FACTORY_BAND;
    end
    else
    begin
      commit_all  <= 1'b0;
      commit_addr <= 1'b0;
      if (start)
      begin
        state    <= S_RX;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'b00;
        sda_oe   <= 1'b0;
      end
      else if (stop)
      begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          S_RX:
          begin
            if (scl_rise)
            begin
              rx_sh   <= {rx_sh[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              state   <= S_RXACK;
              sda_oe  <= 1'b1;
              if (byte_idx != 2'b10)
                byte_idx <= byte_idx + 2'b01;
              if (nv_busy)
              begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
              end
              else if (byte_idx == 2'b00)
              begin
                if (rx_sh[7:1] == {`DEV_ID, bus_nv[2:0]})
                  rw <= rx_sh[0];
                else
                begin
                  state  <= S_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              else if (byte_idx == 2'b01)
              begin
                ptr <= rx_sh;
                if (rx_sh == `ADDR_COMMIT)
                  commit_all <= 1'b1;
              end
              else
              begin
                ptr <= ptr + 8'h01;
                if (ptr == `ADDR_DIV_HI || ptr == `ADDR_TRIM_HI)
                  stage <= rx_sh;
                else if (ptr == `ADDR_DIV_LO)
                begin
                  div_word   <= {stage, rx_sh[7:6], 6'h00};
                  commit_all <= ~inhibit;
                end
                else if (ptr == `ADDR_TRIM_LO)
                begin
                  trim       <= {stage, rx_sh[7:6]};
                  commit_all <= ~inhibit;
                end
                else if (ptr == `ADDR_BUS_NV)
                begin
                  bus_nv      <= rx_sh[3:0];
                  commit_addr <= 1'b1;
                end
                else if (ptr == `ADDR_BAND)
                begin
                  band       <= rx_sh[4:0];
                  commit_all <= ~inhibit;
                end
              end
            end
          end
          S_RXACK:
          begin
            if (scl_fall)
            begin
              if (rw && byte_idx == 2'b01)
              begin
                tx_sh   <= rd_byte;
                sda_oe  <= ~rd_byte[7];
                bit_cnt <= 4'h0;
                state   <= S_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                state  <= S_RX;
              end
            end
          end
          S_TX:
          begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 4'h1;
            else if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                sda_oe <= 1'b0;
                state  <= S_TXACK;
                ptr    <= ptr + 8'h01;
              end
              else
              begin
                tx_sh  <= {tx_sh[6:0], 1'b0};
                sda_oe <= ~tx_sh[6];
              end
            end
          end
          S_TXACK:
          begin
            if (scl_rise && sda_sync[1])
              state <= S_IDLE;
            else if (scl_fall)
            begin
              tx_sh   <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              bit_cnt <= 4'h0;
              state   <= S_TX;
            end
          end
          default:
            state <= S_IDLE;
        endcase
      end
      // Power cycle discards volatile-only changes
      if (recall)
      begin
        div_word <= nv_div;
        trim     <= nv_trim;
        bus_nv   <= nv_bus;
        band     <= nv_band;
      end
    end
  end

  // Nonvolatile storage and write-cycle timer
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nv_div  <= `RST_DIV;
      nv_trim <= `RST_TRIM;
      nv_bus  <= `RST_BUSNV;
      nv_band <= FACTORY_BAND;
      nv_cnt  <= 18'h0_0000;
    end
    else if (commit_all)
    begin
      nv_div  <= div_word;
      nv_trim <= trim;
      nv_bus  <= bus_nv;
      nv_band <= band;
      nv_cnt  <= NV_WRITE_CYCLES;
    end
    else if (commit_addr)
    begin
      nv_bus <= bus_nv;
      nv_cnt <= NV_WRITE_CYCLES;
    end
    else if (nv_busy)
      nv_cnt <= nv_cnt - 18'h0_0001;
  end

  // Oscillator and output controls
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      osc_run         <= 1'b0;
      out_buffer_en   <= 1'b0;
      out_idle_low    <= 1'b0;
      out_idle_hiz    <= 1'b1;
      divide_exponent <= 4'h0;
      dither_rate_div <= `RATE_DIV_4096;
      dither_spread   <= 7'h00;
      osc_trim        <= 10'h000;
      trim_offset_khz <= 13'h0000;
      band_sel        <= 5'h00;
    end
    else
    begin
      osc_run       <= pdn_sync[1];
      out_buffer_en <= pdn_sync[1] & oe_sync[1];
      out_idle_low  <= ~(pdn_sync[1] & oe_sync[1]) & div_word[`DIV_IDLE_LOW];
      out_idle_hiz  <= ~(pdn_sync[1] & oe_sync[1]) & ~div_word[`DIV_IDLE_LOW];
      divide_exponent <= clamp_exp(div_word[`DIV_EXP_HI:`DIV_EXP_LO]);
      case (div_word[`DIV_RATE_HI:`DIV_RATE_LO])
        2'b00:   dither_rate_div <= `RATE_DIV_8192;
        2'b10:   dither_rate_div <= `RATE_DIV_2048;
        default: dither_rate_div <= `RATE_DIV_4096;
      endcase
      if (!dith_sync[1])
        dither_spread <= 7'h00;
      else
        case (div_word[`DIV_DEPTH_HI:`DIV_DEPTH_LO])
          3'b000:  dither_spread <= `DEPTH_0P5;
          3'b001:  dither_spread <= `DEPTH_1;
          3'b010:  dither_spread <= `DEPTH_2;
          3'b100:  dither_spread <= `DEPTH_4;
          3'b111:  dither_spread <= `DEPTH_8;
          default: dither_spread <= 7'h00;
        endcase
      osc_trim        <= trim;
      trim_offset_khz <= {3'b000, trim} * `TRIM_STEP_KHZ;
      band_sel        <= band;
    end
  end

endmodule

/* File: bench/two_wire_master.sv */
// Two-wire bus master model that drives the register port
`timescale 1ns/1ps
module two_wire_master (
  input  wire clk,
  input  wire sda_line,
  output reg  scl,
  output reg  sda_drv
);
  // Both lines released, bus idle
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Wait whole block clock cycles
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: data set while clock low, line sampled at end of high
  task bit_slot(input logic b, output logic r);
    tick(1);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda_line;
    scl <= 1'b0;
  endtask
  // Start: data falls while clock high
  task start;
    tick(1);
    sda_drv <= 1'b1;
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  // Stop: data rises while clock high, bus left idle
  task stop;
    tick(1);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // Byte out, then the slave's acknowledge slot
  task send_byte(input [7:0] b, output logic ack);
    logic   r;
    integer i;
    for (i = 7; i >= 0; i--)
      bit_slot(b[i], r);
    bit_slot(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then our acknowledge or closing not-acknowledge
  task recv_byte(input logic last, output [7:0] d);
    logic   r;
    integer i;
    for (i = 7; i >= 0; i--)
      bit_slot(1'b1, d[i]);
    bit_slot(last, r);
  endtask
endmodule

/* File: bench/clock_cfg_props.sv */
// Port assertions for the clock configuration block
`timescale 1ns/1ps
module clock_cfg_props (
  input wire        clk,
  input wire        reset,
  input wire        sda_oe,
  input wire        dither_enable_pin,
  input wire        output_enable_pin,
  input wire        powerdown_n_pin,
  input wire        osc_run,
  input wire        out_buffer_en,
  input wire        out_idle_low,
  input wire        out_idle_hiz,
  input wire [3:0]  divide_exponent,
  input wire [13:0] dither_rate_div,
  input wire [6:0]  dither_spread,
  input wire        nv_busy
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Decoded fields stay within their legal sets
  a_exp_clamp: assert property (divide_exponent <= 4'h8)
    else $error("exponent above eight");
  a_spread_codes: assert property (dither_spread inside {7'h00, 7'h05, 7'h0a, 7'h14, 7'h28, 7'h50})
    else $error("illegal spread");
  a_rate_codes: assert property (dither_rate_div inside {14'h2000, 14'h1000, 14'h0800})
    else $error("illegal dither rate");
  // Pin qualifiers after synchronisation
  a_spread_pin_off: assert property (!dither_enable_pin [*4] |=> dither_spread == 7'h00)
    else $error("spread with pin low");
  a_pdn_stops_osc: assert property (!powerdown_n_pin [*4] |=> !osc_run && !out_buffer_en)
    else $error("oscillator runs in power down");
  a_oe_buffer_off: assert property (!output_enable_pin [*4] |=> !out_buffer_en)
    else $error("buffer on with enable low");
  a_idle_exclusive: assert property (out_buffer_en |-> !out_idle_low && !out_idle_hiz)
    else $error("idle state while driving");
  // Storage write cycle and bus answers
  a_busy_no_ack: assert property ($rose(sda_oe) |-> !nv_busy)
    else $error("answer during storage write");
  a_busy_length: assert property ($rose(nv_busy) |-> nv_busy [*8])
    else $error("storage write too short");
endmodule

bind dithered_clock_config_regs clock_cfg_props i_props (
  .clk, .reset, .sda_oe, .dither_enable_pin, .output_enable_pin, .powerdown_n_pin,
  .osc_run, .out_buffer_en, .out_idle_low, .out_idle_hiz, .divide_exponent,
  .dither_rate_div, .dither_spread, .nv_busy
);

/* File: bench/tb.sv */
// Self-checking bench for the clock configuration registers
`timescale 1ns/1ps
`include "dithered_clock_map.vh"
module tb;
  localparam [4:0] FBAND = 5'h12;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         dither_enable_pin = 1'b1;
  reg         output_enable_pin = 1'b1;
  reg         powerdown_n_pin = 1'b1;
  reg         power_cycle = 1'b0;
  reg  [2:0]  dev_a = 3'h0;
  integer     busy_cycles = 0;
  integer     n_errors = 0;
  integer     comparisons = 0;
  wire        scl, sda_drv, sda_out, sda_oe, osc_run, out_buffer_en;
  wire        out_idle_low, out_idle_hiz, nv_busy;
  wire [3:0]  divide_exponent;
  wire [13:0] dither_rate_div;
  wire [6:0]  dither_spread;
  wire [9:0]  osc_trim;
  wire [12:0] trim_offset_khz;
  wire [4:0]  band_sel;
  // Open-drain data wire with pull-up
  wire        sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  dithered_clock_config_regs #(.NV_WRITE_CYCLES(18'h000c8), .FACTORY_BAND(FBAND)) i_dut (
    .clk, .reset, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .dither_enable_pin, .output_enable_pin, .powerdown_n_pin, .power_cycle, .osc_run,
    .out_buffer_en, .out_idle_low, .out_idle_hiz, .divide_exponent, .dither_rate_div,
    .dither_spread, .osc_trim, .trim_offset_khz, .band_sel, .nv_busy
  );
  two_wire_master i_master (.clk, .sda_line, .scl, .sda_drv);

  // Clock and storage-busy monitor
  always #25 clk = ~clk;
  always @(posedge clk)
    if (nv_busy === 1'b1)
      busy_cycles <= busy_cycles + 1;

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string what, input [15:0] exp, input [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register write: pointer then n data bytes, high byte first
  task wr(input [7:0] p, input [15:0] v, input integer n, output logic ok);
    logic a;
    i_master.start;
    i_master.send_byte({`DEV_ID, dev_a, 1'b0}, ok);
    i_master.send_byte(p, a);
    ok = ok & a;
    if (n == 2)
    begin
      i_master.send_byte(v[15:8], a);
      ok = ok & a;
    end
    if (n > 0)
    begin
      i_master.send_byte(v[7:0], a);
      ok = ok & a;
    end
    i_master.stop;
  endtask
  // Register read: set pointer, then read n bytes
  task rd(input [7:0] p, input integer n, output [15:0] d);
    logic a;
    d = 16'h0000;
    i_master.start;
    i_master.send_byte({`DEV_ID, dev_a, 1'b0}, a);
    i_master.send_byte(p, a);
    i_master.stop;
    i_master.start;
    i_master.send_byte({`DEV_ID, dev_a, 1'b1}, a);
    if (n == 2)
      i_master.recv_byte(1'b0, d[15:8]);
    i_master.recv_byte(1'b1, d[7:0]);
    i_master.stop;
  endtask
  task nv_wait;
    integer k;
    k = 0;
    while (nv_busy !== 1'b0 && k < 1000)
    begin
      tick(1);
      k++;
    end
    chk("nv_busy", 16'h0000, nv_busy);
  endtask
  function [15:0] spread_of(input [2:0] c);
    case (c)
      3'h0: spread_of = 16'h0005;
      3'h1: spread_of = 16'h000a;
      3'h2: spread_of = 16'h0014;
      3'h4: spread_of = 16'h0028;
      3'h7: spread_of = 16'h0050;
      default: spread_of = 16'h0000;
    endcase
  endfunction

  task t_reset;
    logic [15:0] d;
    rd(`ADDR_DIV_HI, 2, d);
    chk("div word", 16'h6000, d);
    rd(`ADDR_TRIM_HI, 2, d);
    chk("trim word", 16'h7d00, d);
    rd(`ADDR_FACTORY, 1, d);
    chk("factory", FBAND, d);
    chk("rate", 16'h1000, dither_rate_div);
    chk("band", FBAND, band_sel);
    $display("test reset done");
  endtask
  task t_commit;
    logic   ok;
    integer b0;
    b0 = busy_cycles;
    wr(`ADDR_BAND, FBAND, 1, ok);
    chk("auto commit", 16'h0001, busy_cycles != b0);
    nv_wait;
    b0 = busy_cycles;
    wr(`ADDR_BUS_NV, 16'h0009, 1, ok);
    chk("addr commit", 16'h0001, busy_cycles != b0);
    dev_a = 3'h1;
    wr(`ADDR_BAND, FBAND, 1, ok);
    chk("busy nack", 16'h0000, ok);
    nv_wait;
    dev_a = 3'h0;
    wr(`ADDR_BAND, FBAND, 1, ok);
    chk("other addr", 16'h0000, ok);
    dev_a = 3'h1;
    b0 = busy_cycles;
    wr(`ADDR_BAND, FBAND, 1, ok);
    chk("own addr", 16'h0001, ok);
    chk("held write", 16'h0000, busy_cycles != b0);
    $display("test commit done");
  endtask
  task t_div;
    logic [15:0] w [7];
    logic [15:0] d;
    logic        ok;
    integer      i;
    w = '{16'h1a40, 16'h0000, 16'h4800, 16'h9040, 16'h2200, 16'h3bc0, 16'hc440};
    for (i = 0; i < 7; i++)
    begin
      wr(`ADDR_DIV_HI, w[i], 2, ok);
      tick(4);
      chk("rate", (w[i][15:14] == 2'b10) ? 16'h0800 :
                  (w[i][15:14] == 2'b00) ? 16'h2000 : 16'h1000, dither_rate_div);
      chk("spread", spread_of(w[i][13:11]), dither_spread);
      chk("exponent", w[i][9:6] > 4'h8 ? 16'h0008 : w[i][9:6], divide_exponent);
      rd(`ADDR_DIV_HI, 2, d);
      chk("div word", w[i], d);
    end
    dither_enable_pin <= 1'b0;
    tick(5);
    chk("spread off", 16'h0000, dither_spread);
    dither_enable_pin <= 1'b1;
    $display("test divider done");
  endtask
  task t_idle;
    logic [15:0] d;
    logic        ok;
    integer      i;
    for (i = 0; i < 8; i++)
    begin
      rd(`ADDR_DIV_HI, 2, d);
      wr(`ADDR_DIV_HI, {d[15:11], i[2], d[9:0]}, 2, ok);
      powerdown_n_pin <= i[1];
      output_enable_pin <= i[0];
      tick(5);
      chk("osc run", i[1], osc_run);
      chk("buffer", i[1] & i[0], out_buffer_en);
      chk("idle low", !(i[1] && i[0]) && i[2], out_idle_low);
      chk("idle hiz", !(i[1] && i[0]) && !i[2], out_idle_hiz);
      powerdown_n_pin <= 1'b1;
      output_enable_pin <= 1'b1;
    end
    $display("test idle done");
  endtask
  task t_trim;
    logic [15:0] d;
    logic        ok;
    integer      b0;
    wr(`ADDR_TRIM_HI, 16'ha1c0, 2, ok);
    wr(`ADDR_DIV_HI, 16'h6080, 2, ok);
    tick(4);
    chk("trim", 16'h0287, osc_trim);
    chk("trim khz", 16'h0ca3, trim_offset_khz);
    chk("exponent", 16'h0002, divide_exponent);
    rd(`ADDR_TRIM_HI, 2, d);
    chk("trim word", 16'ha1c0, d);
    rd(`ADDR_FACTORY, 1, d);
    wr(`ADDR_BAND, d + 16'h0006, 1, ok);
    wr(`ADDR_FACTORY, 16'h0000, 1, ok);
    rd(`ADDR_FACTORY, 1, d);
    chk("factory", FBAND, d);
    chk("band", FBAND + 6, band_sel);
    b0 = busy_cycles;
    wr(`ADDR_COMMIT, 16'h0000, 0, ok);
    chk("commit cmd", 16'h0001, busy_cycles != b0);
    nv_wait;
    wr(`ADDR_TRIM_HI, 16'h4600, 2, ok);
    tick(4);
    chk("trim", 16'h0118, osc_trim);
    power_cycle <= 1'b1;
    tick(2);
    power_cycle <= 1'b0;
    tick(5);
    chk("trim recall", 16'h0287, osc_trim);
    chk("band recall", FBAND + 6, band_sel);
    $display("test storage done");
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    tick(16);
    reset <= 1'b0;
    tick(4);
    t_reset;
    t_commit;
    t_div;
    t_idle;
    t_trim;
    wrap_up;
  end
  // Watchdog against a hung bus
  initial
  begin
    #2000000;
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up;
  end
endmodule
